// *** design/cdtor_regs.sv ***
// AHB-Lite register bank overriding the D-PHY transmit timing counts
//
// Behaviour
// - Index 0x40: bit 7 selects own clock prepare value, reset 0x5.
// - Index 0x41: bit 7 selects own clock zero value, reset 0x1B.
// - Index 0x42: bit 7 selects own clock trail value, reset 0x0B.
// - Index 0x43: bit 7 selects own clock post value, reset 0x0A.
// - Index 0x44: bit 7 selects own data prepare value, reset 0x6.
// - Index 0x45: bit 7 selects own data zero value, reset 0x0C.
// - Override clear: value field read-only, reads the derived value.
// - Override set: value field writable and drives the timing.
// - Reset values fit 800 Mbps; derived values follow the lane rate.
// - Override bits reset to zero, so all six start derived.
`timescale 1ns/1ps
module cdtor_regs #(
  parameter int ADDR_DEC_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output cdtor_pkg::cdtor_timing_t phy_timing,
  output logic [cdtor_pkg::RATE_W-1:0] lane_rate
);
  import cdtor_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // The decoded window must reach the highest register index
  if (ADDR_DEC_W < IDX_W + IDX_LSB || ADDR_DEC_W > 32) begin : g_chk
    $error("ADDR_DEC_W out of range");
  end

  localparam logic HRESP_OKAY = 1'b0;
  localparam int UPPER_W = 32 - ADDR_DEC_W;
  localparam int ADDR_TOP = ADDR_DEC_W - 1;

  // ------------------------------------------------------------------
  // Register index table
  // ------------------------------------------------------------------
  localparam logic [NUM_TIMING-1:0][IDX_W-1:0] TIMING_IDX = {
    IDX_DATA_LANE_ZERO_TIME,
    IDX_DATA_LANE_PREPARE_TIME,
    IDX_CLK_LANE_POST_TIME,
    IDX_CLK_LANE_TRAIL_TIME,
    IDX_CLK_LANE_ZERO_TIME,
    IDX_CLK_LANE_PREPARE_TIME
  };

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  function automatic logic rate_legal(input logic [RATE_W-1:0] code);
    rate_legal = (code == RATE_400) || (code == RATE_800) ||
                 (code == RATE_1200) || (code == RATE_1500) ||
                 (code == RATE_1600);
  endfunction

  function automatic logic [NUM_TIMING-1:0] timing_hit(
    input logic [IDX_W-1:0] idx
  );
    for (int i = 0; i < NUM_TIMING; i++) begin
      timing_hit[i] = (idx == TIMING_IDX[i]);
    end
  endfunction

  function automatic logic [IDX_W-1:0] addr_index(
    input logic [31:0] addr
  );
    addr_index = addr[IDX_W+IDX_LSB-1:IDX_LSB];
  endfunction

  // ------------------------------------------------------------------
  // Address phase
  // ------------------------------------------------------------------
  // Bursts and protection are accepted as plain singles
  wire logic addr_upper_zero;
  wire logic addr_mid_zero;
  wire logic addr_taken;
  wire logic addr_mapped;
  wire logic [IDX_W-1:0] addr_idx;
  wire logic [NUM_TIMING-1:0] addr_timing_hit;

  if (UPPER_W > 0) begin : g_upper
    assign addr_upper_zero = (haddr[31:ADDR_DEC_W] == '0);
  end else begin : g_noupper
    assign addr_upper_zero = 1'b1;
  end

  // Bits between the index and the decoded top exist only when wider
  if (ADDR_DEC_W > IDX_W + IDX_LSB) begin : g_mid
    assign addr_mid_zero = (haddr[ADDR_TOP:IDX_W+IDX_LSB] == '0);
  end else begin : g_nomid
    assign addr_mid_zero = 1'b1;
  end

  assign addr_taken = hsel && htrans[1] && hready;
  assign addr_idx = addr_index(haddr);
  assign addr_timing_hit = timing_hit(addr_idx);
  assign addr_mapped = addr_upper_zero &&
                       addr_mid_zero &&
                       ((|addr_timing_hit) ||
                        (addr_idx == IDX_LANE_RATE_SELECT) ||
                        (addr_idx == IDX_OVERRIDE_MAP));

  // ------------------------------------------------------------------
  // Data phase tracking
  // ------------------------------------------------------------------
  logic dp_valid;
  cdtor_dphase_t dp;
  logic next_dp_valid;
  cdtor_dphase_t next_dp;

  // Unmapped addresses still complete, so the bus never stalls on them
  assign next_dp_valid = hready ? (addr_taken && addr_mapped) : dp_valid;
  assign next_dp.write = hready ? hwrite : dp.write;
  assign next_dp.index = hready ? addr_idx : dp.index;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp <= '0;
    end else begin
      dp_valid <= next_dp_valid;
      dp <= next_dp;
    end
  end

  // ------------------------------------------------------------------
  // Write strobes, taken at the end of the data phase
  // ------------------------------------------------------------------
  wire logic dp_write;
  wire logic [NUM_TIMING-1:0] field_wr;
  wire logic rate_wr;

  assign dp_write = dp_valid && dp.write && hready;
  assign field_wr = dp_write ? timing_hit(dp.index) : '0;
  assign rate_wr = dp_write && (dp.index == IDX_LANE_RATE_SELECT);

  // ------------------------------------------------------------------
  // Lane rate select
  // ------------------------------------------------------------------
  // Unsupported rate codes are dropped so the PHY never sees one
  logic [RATE_W-1:0] rate_sel;
  wire logic [RATE_W-1:0] wr_rate;
  wire logic [RATE_W-1:0] next_rate_sel;

  assign wr_rate = hwdata[RATE_W-1:0];
  assign next_rate_sel = (rate_wr && rate_legal(wr_rate)) ?
                         wr_rate : rate_sel;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_sel <= RATE_RESET;
    end else begin
      rate_sel <= next_rate_sel;
    end
  end

  // ------------------------------------------------------------------
  // Automatic derivation
  // ------------------------------------------------------------------
  cdtor_timing_t auto_timing;
  cdtor_vals_t auto_vals;

  cdtor_auto u_auto (
    .hclk(hclk),
    .hresetn(hresetn),
    .rate_code(rate_sel),
    .auto_timing(auto_timing)
  );

  assign auto_vals = cdtor_vals_t'(auto_timing);

  // ------------------------------------------------------------------
  // The six override registers
  // ------------------------------------------------------------------
  logic [NUM_TIMING-1:0] override_bits;
  cdtor_vals_t next_eff_vals;
  logic [NUM_TIMING-1:0][REG_W-1:0] next_rb;
  cdtor_vals_t rst_vals;

  assign rst_vals = cdtor_vals_t'(RST_TIMING);

  for (genvar g = 0; g < NUM_TIMING; g++) begin : g_field
    cdtor_field #(
      .RESET_VALUE(RST_TIMING[g*VAL_W +: VAL_W])
    ) u_field (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(field_wr[g]),
      .wr_data(hwdata[REG_W-1:0]),
      .auto_value(auto_vals[g]),
      .override(override_bits[g]),
      .next_effective(next_eff_vals[g]),
      .next_readback(next_rb[g])
    );
  end

  // ------------------------------------------------------------------
  // Read data, formed in the address phase from the post-write state
  // ------------------------------------------------------------------
  // Using next state lets a read right after a write see its result
  wire logic rd_taken;
  wire logic [NUM_TIMING-1:0] rd_hit;
  logic [REG_W-1:0] rd_byte;
  wire logic [31:0] next_hrdata;

  assign rd_taken = addr_taken && addr_mapped && !hwrite;
  assign rd_hit = timing_hit(addr_idx);

  always_comb begin
    rd_byte = '0;
    for (int i = 0; i < NUM_TIMING; i++) begin
      if (rd_hit[i]) begin
        rd_byte = next_rb[i];
      end
    end
    if (addr_idx == IDX_LANE_RATE_SELECT) begin
      rd_byte = REG_W'(next_rate_sel);
    end
    if (addr_idx == IDX_OVERRIDE_MAP) begin
      for (int i = 0; i < NUM_TIMING; i++) begin
        rd_byte[i] = next_rb[i][OV_BIT];
      end
    end
  end

  // Bits above the byte read as zero
  assign next_hrdata = rd_taken ? {{(32-REG_W){1'b0}}, rd_byte} : '0;

  // ------------------------------------------------------------------
  // Bus outputs
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hrdata <= hready ? next_hrdata : hrdata;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ------------------------------------------------------------------
  // Timing outputs toward the PHY
  // ------------------------------------------------------------------
  // Registered so the PHY sees one clean change per write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_timing <= RST_TIMING;
      lane_rate <= RATE_RESET;
    end else begin
      phy_timing <= cdtor_timing_t'(next_eff_vals);
      lane_rate <= rate_sel;
    end
  end

endmodule

// *** include/cdtor_pkg.sv ***
// Constants and types of the D-PHY timing override register bank
package cdtor_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_CLK_LANE_PREPARE_TIME = 8'h40;
  localparam logic [7:0] IDX_CLK_LANE_ZERO_TIME = 8'h41;
  localparam logic [7:0] IDX_CLK_LANE_TRAIL_TIME = 8'h42;
  localparam logic [7:0] IDX_CLK_LANE_POST_TIME = 8'h43;
  localparam logic [7:0] IDX_DATA_LANE_PREPARE_TIME = 8'h44;
  localparam logic [7:0] IDX_DATA_LANE_ZERO_TIME = 8'h45;
  localparam logic [7:0] IDX_LANE_RATE_SELECT = 8'h50;
  localparam logic [7:0] IDX_OVERRIDE_MAP = 8'h51;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int NUM_TIMING = 6;
  localparam int VAL_W = 7;
  localparam int OV_BIT = 7;
  localparam int REG_W = 8;
  localparam int RATE_W = 3;
  localparam int MBPS_W = 11;

  // Slot order inside every timing array
  localparam int SLOT_CLK_PREPARE = 0;
  localparam int SLOT_CLK_ZERO = 1;
  localparam int SLOT_CLK_TRAIL = 2;
  localparam int SLOT_CLK_POST = 3;
  localparam int SLOT_DATA_PREPARE = 4;
  localparam int SLOT_DATA_ZERO = 5;

  // ------------------------------------------------------------------
  // Reset values, valid at the 800 Mbps lane rate
  // ------------------------------------------------------------------
  localparam logic [VAL_W-1:0] RST_CLK_PREPARE = 7'h05;
  localparam logic [VAL_W-1:0] RST_CLK_ZERO = 7'h1B;
  localparam logic [VAL_W-1:0] RST_CLK_TRAIL = 7'h0B;
  localparam logic [VAL_W-1:0] RST_CLK_POST = 7'h0A;
  localparam logic [VAL_W-1:0] RST_DATA_PREPARE = 7'h06;
  localparam logic [VAL_W-1:0] RST_DATA_ZERO = 7'h0C;
  localparam logic RST_OVERRIDE = 1'b0;

  // ------------------------------------------------------------------
  // Lane rate codes and their rates
  // ------------------------------------------------------------------
  localparam logic [RATE_W-1:0] RATE_400 = 3'h0;
  localparam logic [RATE_W-1:0] RATE_800 = 3'h1;
  localparam logic [RATE_W-1:0] RATE_1200 = 3'h2;
  localparam logic [RATE_W-1:0] RATE_1500 = 3'h3;
  localparam logic [RATE_W-1:0] RATE_1600 = 3'h4;
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_800;
  localparam logic [MBPS_W-1:0] MBPS_400 = 11'h190;
  localparam logic [MBPS_W-1:0] MBPS_800 = 11'h320;
  localparam logic [MBPS_W-1:0] MBPS_1200 = 11'h4B0;
  localparam logic [MBPS_W-1:0] MBPS_1500 = 11'h5DC;
  localparam logic [MBPS_W-1:0] MBPS_1600 = 11'h640;
  localparam logic [MBPS_W-1:0] MBPS_REF = MBPS_800;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  // Last field is lowest, so a cast to cdtor_vals_t puts slot 0 first
  typedef struct packed {
    logic [VAL_W-1:0] data_zero_value;
    logic [VAL_W-1:0] data_prepare_value;
    logic [VAL_W-1:0] clk_post_value;
    logic [VAL_W-1:0] clk_trail_value;
    logic [VAL_W-1:0] clk_zero_value;
    logic [VAL_W-1:0] clk_prepare_value;
  } cdtor_timing_t;

  typedef logic [NUM_TIMING-1:0][VAL_W-1:0] cdtor_vals_t;

  typedef struct packed {
    logic write;
    logic [IDX_W-1:0] index;
  } cdtor_dphase_t;

  localparam cdtor_timing_t RST_TIMING = '{
    data_zero_value: RST_DATA_ZERO,
    data_prepare_value: RST_DATA_PREPARE,
    clk_post_value: RST_CLK_POST,
    clk_trail_value: RST_CLK_TRAIL,
    clk_zero_value: RST_CLK_ZERO,
    clk_prepare_value: RST_CLK_PREPARE
  };

endpackage

// *** design/cdtor_auto.sv ***
// Automatic derivation of the D-PHY timing counts from the lane rate
`timescale 1ns/1ps
module cdtor_auto (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [cdtor_pkg::RATE_W-1:0] rate_code,
  output cdtor_pkg::cdtor_timing_t auto_timing
);
  import cdtor_pkg::*;

  // ------------------------------------------------------------------
  // Rate lookup and scaling
  // ------------------------------------------------------------------
  function automatic logic [MBPS_W-1:0] rate_mbps(
    input logic [RATE_W-1:0] code
  );
    unique case (code)
      RATE_400: rate_mbps = MBPS_400;
      RATE_1200: rate_mbps = MBPS_1200;
      RATE_1500: rate_mbps = MBPS_1500;
      RATE_1600: rate_mbps = MBPS_1600;
      default: rate_mbps = MBPS_800;
    endcase
  endfunction

  // Counts are in byte clocks, so they grow with the rate; rounded
  function automatic logic [VAL_W-1:0] scale(
    input logic [VAL_W-1:0] base,
    input logic [MBPS_W-1:0] mbps
  );
    logic [VAL_W+MBPS_W-1:0] prod;
    logic [VAL_W+MBPS_W-1:0] quot;
    prod = {{MBPS_W{1'b0}}, base} * {{VAL_W{1'b0}}, mbps};
    quot = (prod + (VAL_W+MBPS_W)'(MBPS_REF >> 1)) /
           (VAL_W+MBPS_W)'(MBPS_REF);
    // Saturate rather than wrap at the top of the field
    if (quot > (VAL_W+MBPS_W)'({VAL_W{1'b1}})) begin
      scale = {VAL_W{1'b1}};
    end else begin
      scale = quot[VAL_W-1:0];
    end
  endfunction

  // ------------------------------------------------------------------
  // Recompute on every edge, so a new rate shows one cycle later
  // ------------------------------------------------------------------
  wire logic [MBPS_W-1:0] cur_mbps = rate_mbps(rate_code);
  cdtor_vals_t base_vals;
  cdtor_vals_t next_vals;
  assign base_vals = cdtor_vals_t'(RST_TIMING);

  always_comb begin
    for (int i = 0; i < NUM_TIMING; i++) begin
      next_vals[i] = scale(base_vals[i], cur_mbps);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_timing <= RST_TIMING;
    end else begin
      auto_timing <= cdtor_timing_t'(next_vals);
    end
  end

endmodule

// *** design/cdtor_field.sv ***
// One override register: override bit plus a 7-bit timing value
`timescale 1ns/1ps
module cdtor_field #(
  parameter logic [cdtor_pkg::VAL_W-1:0] RESET_VALUE = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [cdtor_pkg::REG_W-1:0] wr_data,
  input wire logic [cdtor_pkg::VAL_W-1:0] auto_value,
  output logic override,
  output logic [cdtor_pkg::VAL_W-1:0] next_effective,
  output logic [cdtor_pkg::REG_W-1:0] next_readback
);
  import cdtor_pkg::*;

  logic [VAL_W-1:0] stored;
  logic next_override;
  logic [VAL_W-1:0] next_stored;

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  // Value is taken only when the same write leaves override set
  assign next_override = wr_en ? wr_data[OV_BIT] : override;
  assign next_stored = (wr_en && wr_data[OV_BIT]) ?
                       wr_data[VAL_W-1:0] : stored;
  assign next_effective = next_override ? next_stored : auto_value;
  assign next_readback = {next_override,
                          next_override ? next_stored : auto_value};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      override <= RST_OVERRIDE;
      stored <= RESET_VALUE;
    end else begin
      override <= next_override;
      stored <= next_stored;
    end
  end

endmodule

// *** dv/cdtor_regs_chk.sv ***
// Concurrent checks of the timing override bank at its top-level ports
`timescale 1ns/1ps
module cdtor_regs_chk #(
  parameter int ADDR_DEC_W = 10
) (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [2:0] hburst,
  input logic [3:0] hprot,
  input logic hready,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input cdtor_pkg::cdtor_timing_t phy_timing,
  input logic [cdtor_pkg::RATE_W-1:0] lane_rate
);
  import cdtor_pkg::*;
  // ------------------------------------------------------------------
  // Data phase tracking
  // ------------------------------------------------------------------
  logic d_act, d_wr, d_ok;
  logic [IDX_W-1:0] d_idx;
  wire take = hsel && htrans[1] && hready;
  wire in_map = haddr[31:ADDR_DEC_W] == '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_act <= 1'b0;
      d_wr <= 1'b0;
      d_idx <= '0;
      d_ok <= 1'b0;
    end else if (hready) begin
      d_act <= take;
      d_wr <= hwrite;
      d_idx <= haddr[IDX_LSB +: IDX_W];
      d_ok <= in_map;
    end
  end
  wire slot_hit = d_ok && d_idx >= IDX_CLK_LANE_PREPARE_TIME &&
                  d_idx <= IDX_DATA_LANE_ZERO_TIME;
  wire [2:0] slot = 3'(d_idx - IDX_CLK_LANE_PREPARE_TIME);
  wire wr_hit = d_act && d_wr && hready && slot_hit;
  wire rd_ph = d_act && !d_wr;
  wire rate_sel = d_ok && d_idx == IDX_LANE_RATE_SELECT;
  wire mapped = slot_hit || rate_sel || (d_ok && d_idx == IDX_OVERRIDE_MAP);
  wire [VAL_W-1:0] wval = hwdata[VAL_W-1:0];
  wire [RATE_W-1:0] wrate = hwdata[RATE_W-1:0];
  wire rate_wr = d_act && d_wr && hready && rate_sel && wrate <= RATE_1600;
  cdtor_vals_t vals;
  assign vals = cdtor_vals_t'(phy_timing);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
  property p_rst_vals;
    $rose(hresetn) |-> phy_timing == RST_TIMING && lane_rate == RATE_RESET;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset set");
  // Skips a second write to the bank in the next cycle, which may overtake
  property p_ov_apply;
    wr_hit && hwdata[OV_BIT] ##1 !wr_hit |=>
      vals[$past(slot, 2)] == $past(wval, 2);
  endproperty
  a_ov_apply: assert property (p_ov_apply) else $error("value not applied");
  property p_read_hi; rd_ph |-> hrdata[31:REG_W] == '0; endproperty
  a_read_hi: assert property (p_read_hi) else $error("upper read bits set");
  property p_unmapped; rd_ph && !mapped |-> hrdata == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_idle_zero; !rd_ph |-> hrdata == '0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stale read data");
  property p_hold;
    $changed(phy_timing) |-> $past(wr_hit) || $past(wr_hit, 2) ||
      $past(lane_rate) != $past(lane_rate, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("timing moved alone");
  property p_rate;
    rate_wr ##1 !rate_wr |-> ##1 lane_rate == $past(wrate, 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate not taken");
  c_ov: cover property (wr_hit && hwdata[OV_BIT]);
  c_rate: cover property (rate_wr);
  c_unmapped: cover property (rd_ph && !mapped);
endmodule

bind cdtor_regs cdtor_regs_chk #(.ADDR_DEC_W(ADDR_DEC_W)) u_cdtor_regs_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
  .hprot(hprot), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .phy_timing(phy_timing),
  .lane_rate(lane_rate)
);

// *** dv/cdtor_rx_model.sv ***
// Downstream receiver stand-in that samples the timing set it is given
`timescale 1ns/1ps
module cdtor_rx_model (
  input wire logic hclk,
  input wire logic hresetn,
  input cdtor_pkg::cdtor_timing_t phy_timing,
  input wire logic [cdtor_pkg::RATE_W-1:0] lane_rate,
  output cdtor_pkg::cdtor_timing_t rx_timing,
  output logic [cdtor_pkg::RATE_W-1:0] rx_rate
);
  import cdtor_pkg::*;
  // Sampled every cycle, so a late update shows up one cycle late here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_timing <= RST_TIMING;
      rx_rate <= RATE_RESET;
    end else begin
      rx_timing <= phy_timing;
      rx_rate <= lane_rate;
    end
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench of the timing override register bank
`timescale 1ns/1ps
module tb;
  import cdtor_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  cdtor_timing_t phy_timing, rx_timing;
  logic [RATE_W-1:0] lane_rate, rx_rate, rate;
  logic ov [NUM_TIMING];
  logic [VAL_W-1:0] val [NUM_TIMING];
  logic [31:0] x;
  int miscompares = 0;
  int n_tests = 0;

  cdtor_regs u_cdtor_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0),
    .hprot(4'h3), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phy_timing(phy_timing),
    .lane_rate(lane_rate)
  );
  cdtor_rx_model u_cdtor_rx_model (
    .hclk(hclk), .hresetn(hresetn), .phy_timing(phy_timing),
    .lane_rate(lane_rate), .rx_timing(rx_timing), .rx_rate(rx_rate)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ------------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------------
  function automatic logic [VAL_W-1:0] auto_val(int s, logic [2:0] c);
    cdtor_vals_t b = cdtor_vals_t'(RST_TIMING);
    logic [MBPS_W-1:0] m [5] = '{MBPS_400, MBPS_800, MBPS_1200, MBPS_1500,
                                 MBPS_1600};
    int v;
    v = (int'(b[s]) * int'(m[c]) + 400) / 800;
    return (v > 127) ? 7'h7F : VAL_W'(v);
  endfunction
  function automatic logic [REG_W-1:0] exp_reg(int s);
    return ov[s] ? {1'b1, val[s]} : {1'b0, auto_val(s, rate)};
  endfunction
  function automatic logic [41:0] exp_phy();
    cdtor_vals_t v;
    logic [REG_W-1:0] r;
    for (int s = 0; s < NUM_TIMING; s++) begin
      r = exp_reg(s);
      v[s] = r[VAL_W-1:0];
    end
    return v;
  endfunction
  function automatic logic [31:0] addr_of(logic [IDX_W-1:0] i);
    return {22'h0, i, 2'b00};
  endfunction
  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic compare(string what, logic [41:0] exp, logic [41:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Entered just after a rising edge; one transfer at a time
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd,
                     output logic [31:0] rdv);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask
  task automatic wr_reg(int s, logic [REG_W-1:0] d);
    bus(1'b1, addr_of(IDX_CLK_LANE_PREPARE_TIME + 8'(s)), {24'h0, d}, x);
    if (d[OV_BIT]) val[s] = d[VAL_W-1:0];
    ov[s] = d[OV_BIT];
  endtask
  task automatic chk_reg(int s);
    bus(1'b0, addr_of(IDX_CLK_LANE_PREPARE_TIME + 8'(s)), 32'h0, x);
    compare("timing register", {34'h0, exp_reg(s)}, {10'h0, x});
  endtask
  task automatic wr_rate(logic [RATE_W-1:0] c);
    bus(1'b1, addr_of(IDX_LANE_RATE_SELECT), {29'h0, c}, x);
    if (c <= RATE_1600) rate = c;
    // Derived values follow the new rate one edge later
    @(posedge hclk);
  endtask
  // Rate to auto to output to receiver takes three edges
  task automatic chk_phy();
    repeat (4) @(posedge hclk);
    compare("phy timing", exp_phy(), rx_timing);
    compare("lane rate", {39'h0, rate}, {39'h0, rx_rate});
  endtask
  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int s = 0; s < NUM_TIMING; s++) ov[s] = 1'b0;
    rate = RATE_RESET;
    @(posedge hclk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    conclude();
  end
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hwdata = '0;
    void'($urandom(32'hadfe));
    do_reset();
    for (int s = 0; s < NUM_TIMING; s++) chk_reg(s);
    chk_phy();
    $display("test reset_values done");
    for (int s = 0; s < NUM_TIMING; s++) begin
      wr_reg(s, {1'b0, 7'($urandom)});
      chk_reg(s);
    end
    chk_phy();
    $display("test read_only done");
    for (int s = 0; s < NUM_TIMING; s++) begin
      wr_reg(s, {1'b1, (s < 2) ? {7{s[0]}} : 7'($urandom)});
      chk_reg(s);
    end
    chk_phy();
    $display("test override done");
    for (int s = 3; s < NUM_TIMING; s++) wr_reg(s, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr_rate(3'(c));
      chk_phy();
      for (int s = 0; s < NUM_TIMING; s++) chk_reg(s);
      bus(1'b0, addr_of(IDX_OVERRIDE_MAP), 32'h0, x);
      compare("override map", {36'h0, ov[5], ov[4], ov[3], ov[2], ov[1],
              ov[0]}, {10'h0, x});
    end
    $display("test lane_rate done");
    bus(1'b0, addr_of(8'h46), 32'h0, x);
    compare("unmapped read", 42'h0, {10'h0, x});
    bus(1'b1, addr_of(IDX_CLK_LANE_PREPARE_TIME) | 32'h400, 32'h0000_00AA, x);
    bus(1'b0, addr_of(IDX_CLK_LANE_PREPARE_TIME) | 32'h400, 32'h0, x);
    compare("aliased read", 42'h0, {10'h0, x});
    chk_reg(0);
    $display("test unmapped done");
    repeat (60) begin
      if ($urandom_range(0, 7) == 0) wr_rate(3'($urandom));
      if ($urandom_range(0, 1) == 1) wr_reg(3, 8'($urandom));
      chk_reg(3);
      wr_reg($urandom_range(0, 5), 8'($urandom));
      chk_reg($urandom_range(0, 5));
    end
    chk_phy();
    $display("test random done");
    do_reset();
    for (int s = 0; s < NUM_TIMING; s++) chk_reg(s);
    chk_phy();
    $display("test second_reset done");
    conclude();
  end
endmodule
